/* fpec_mem.sv */
module fpec_mem (
   input wire logic clk_sys,
   fpec_mem_if.array mem
);
   import fpec_pkg::*;

   logic [FPEC_DATA_W-1:0] cells[2**FPEC_MEM_AW];
   logic [FPEC_DATA_W-1:0] rdata_reg;

   // single port; read data is registered, one cycle after the address
   always_ff @(posedge clk_sys) begin
      if (mem.we) begin
         cells[mem.addr] <= mem.wdata;
      end
      rdata_reg <= cells[mem.addr];
   end

   assign mem.rdata = rdata_reg;
endmodule

/* fpec_mem_if.sv */
interface fpec_mem_if;
   import fpec_pkg::*;
   logic [FPEC_MEM_AW-1:0] addr;
   logic we;
   logic [FPEC_DATA_W-1:0] wdata;
   logic [FPEC_DATA_W-1:0] rdata;
   modport ctrl (output addr, output we, output wdata, input rdata);
   modport array (input addr, input we, input wdata, output rdata);
endinterface

/* fpec_pkg.sv */
package fpec_pkg;
   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [15:0] FPEC_IDX_MODE = 16'hff80;
   localparam logic [15:0] FPEC_IDX_GAP = 16'hff81;
   localparam logic [15:0] FPEC_IDX_LARGE = 16'hff82;
   localparam logic [15:0] FPEC_IDX_SMALL = 16'hff83;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int FPEC_BIT_SUPPLY = 7;
   localparam int FPEC_BIT_ERASE_VERIFY = 3;
   localparam int FPEC_BIT_PROGRAM_VERIFY = 2;
   localparam int FPEC_BIT_ERASE = 1;
   localparam int FPEC_BIT_PROG = 0;
   localparam logic [3:0] FPEC_MODE_RESET = 4'h0;
   localparam logic [7:0] FPEC_MODE_SUPPLY_RESET = 8'h80;
   localparam logic [7:0] FPEC_LARGE_RESET = 8'hf0;
   localparam logic [3:0] FPEC_LARGE_FIXED = 4'hf;
   localparam logic [7:0] FPEC_SMALL_RESET = 8'h00;
   localparam logic [7:0] FPEC_LOCKED_READ = 8'hff;

   // ----------------------------------------------------------------
   // array map
   // ----------------------------------------------------------------
   localparam int FPEC_MEM_AW = 14;
   localparam int FPEC_DATA_W = 16;
   localparam logic [14:0] FPEC_TOP_32K = 15'h7fff;
   localparam logic [14:0] FPEC_TOP_24K = 15'h5fff;
   localparam logic [14:0] FPEC_TOP_16K = 15'h3fff;
   localparam logic [14:0] FPEC_SB_128_END = 15'h0200;
   localparam logic [14:0] FPEC_SB_512_END = 15'h0400;
   localparam logic [14:0] FPEC_SMALL_END = 15'h1000;
   localparam logic [14:0] FPEC_LARGE0_END = 15'h2000;
   localparam logic [15:0] FPEC_ERASED = 16'hffff;

   typedef enum logic [1:0] {
      FPEC_ST_IDLE,
      FPEC_ST_ACCESS,
      FPEC_ST_DONE,
      FPEC_ST_ERASE
   } fpec_state_e;
endpackage

/* fpec_tb.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import fpec_pkg::*;

   // ----------------------------------------------------------------
   // stimulus and observation
   // ----------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic programming_supply_pin = 1'b1;
   logic low_power_req = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [17:0] wb_adr_i = 18'h00000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o;
   logic [31:0] wb_dat_o_16k;
   logic wb_ack_o;
   logic [3:0] active_mode_o;
   int fails = 0;
   int check_count = 0;
   logic [17:0] a_mode, a_gap, a_large, a_small;

   assign a_mode = {FPEC_IDX_MODE, 2'b00};
   assign a_gap = {FPEC_IDX_GAP, 2'b00};
   assign a_large = {FPEC_IDX_LARGE, 2'b00};
   assign a_small = {FPEC_IDX_SMALL, 2'b00};

   // 8 ns period
   always #4 clk_sys = ~clk_sys;

   fpec_top #(.FLASH_KBYTES(32)) dut (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .programming_supply_pin(programming_supply_pin),
      .low_power_req(low_power_req),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .active_mode_o(active_mode_o)
   );

   // smallest variant on the same bus; it answers in step with dut
   // until the first erase sweep, so it is only judged before one
   fpec_top #(.FLASH_KBYTES(16)) dut_16k (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .programming_supply_pin(programming_supply_pin),
      .low_power_req(low_power_req),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o_16k),
      .wb_ack_o(),
      .active_mode_o()
   );

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one classic cycle; an erase sweep may stall it, hence the long bound
   task automatic bus(input logic we, input logic [17:0] adr,
                      input logic [3:0] sel, input logic [31:0] dat,
                      output logic [31:0] rdat, output int lat);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      lat = 0;
      do begin
         @(posedge clk_sys);
         lat++;
         if (lat > 20000) begin
            fails++;
            $display("unexpected timeout waiting for acknowledge");
            complete_run();
         end
      end while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [17:0] adr, input logic [31:0] dat);
      logic [31:0] r;
      int l;
      bus(1'b1, adr, (adr[17:16] == 2'b11) ? 4'h1 : 4'h3, dat, r, l);
   endtask

   task automatic rd(input string name, input logic [17:0] adr,
                     input logic [31:0] exp);
      logic [31:0] r;
      int l;
      bus(1'b0, adr, 4'h3, 32'h00000000, r, l);
      check(name, r, exp);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values();
      logic [31:0] r;
      int l;
      // nothing past the small variant's top
      bus(1'b0, 18'h08000, 4'h3, 32'h00000000, r, l);
      check("beyond 16k top", wb_dat_o_16k, 32'h00000000);
      rd("mode after reset", a_mode, {24'h0, FPEC_MODE_SUPPLY_RESET});
      rd("large after reset", a_large, {24'h0, FPEC_LARGE_RESET});
      rd("small after reset", a_small, {24'h0, FPEC_SMALL_RESET});
      wr(a_large, 32'h0000000f);
      rd("large fixed nibble", a_large, 32'h000000ff);
      check("large 16k kept", wb_dat_o_16k, 32'h000000ff);
      wr(a_large, 32'h00000005);
      rd("large partial", a_large, 32'h000000f5);
      $display("test reset_values done");
   endtask

   task automatic t_modes();
      for (int b = 0; b < 4; b++) begin
         wr(a_mode, 32'h1 << b);
         check("active mode", {28'h0, active_mode_o}, 32'h1 << b);
         rd("mode set", a_mode, 32'h80 | (32'h1 << b));
         wr(a_mode, 32'h00000000);
         check("mode left", {28'h0, active_mode_o}, 32'h0);
      end
      $display("test modes done");
   endtask

   task automatic t_erase_program();
      logic [31:0] r;
      int l;
      wr(a_large, 32'h00000001);
      wr(a_small, 32'h00000003);
      wr(a_mode, 32'h00000002);
      wr(a_mode, 32'h00000000);
      rd("erased block0", 18'h00000, {16'h0, FPEC_ERASED});
      rd("erased block1", 18'h00100, {16'h0, FPEC_ERASED});
      rd("erased large0", 18'h02000, {16'h0, FPEC_ERASED});
      wr(a_small, 32'h00000001);
      wr(a_mode, 32'h00000001);
      wr(18'h00000, 32'h00001234);
      wr(18'h00100, 32'h00000000);
      wr(18'h02000, 32'h00005a5a);
      wr(a_mode, 32'h00000000);
      bus(1'b0, 18'h00000, 4'h3, 32'h0, r, l);
      check("programmed word", r, 32'h00001234);
      check("read latency", l, 32'h3);
      rd("unselected kept", 18'h00100, 32'h0000ffff);
      rd("large programmed", 18'h02000, 32'h00005a5a);
      $display("test erase_program done");
   endtask

   task automatic t_low_power();
      wr(a_small, 32'h0000000a);
      wr(a_large, 32'h00000003);
      wr(a_mode, 32'h00000004);
      @(posedge clk_sys);
      low_power_req <= 1'b1;
      @(posedge clk_sys);
      low_power_req <= 1'b0;
      rd("mode low power", a_mode, 32'h00000080);
      rd("large low power", a_large, 32'h000000f0);
      rd("small low power", a_small, 32'h00000000);
      check("active low power", {28'h0, active_mode_o}, 32'h0);
      $display("test low_power done");
   endtask

   task automatic t_supply_loss();
      wr(a_small, 32'h00000055);
      wr(a_mode, 32'h00000008);
      @(posedge clk_sys);
      programming_supply_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      // locked window reads all ones and drops writes
      rd("mode locked", a_mode, {24'h0, FPEC_LOCKED_READ});
      rd("gap locked", a_gap, {24'h0, FPEC_LOCKED_READ});
      rd("large locked", a_large, {24'h0, FPEC_LOCKED_READ});
      wr(a_small, 32'h00000033);
      rd("small locked", a_small, {24'h0, FPEC_LOCKED_READ});
      check("active locked", {28'h0, active_mode_o}, 32'h0);
      @(posedge clk_sys);
      programming_supply_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd("mode resupplied", a_mode, 32'h00000080);
      rd("large resupplied", a_large, 32'h000000f0);
      rd("small resupplied", a_small, 32'h00000000);
      $display("test supply_loss done");
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_reset_values();
      t_modes();
      t_erase_program();
      t_low_power();
      t_supply_loss();
      complete_run();
   end
endmodule

/* fpec_top.sv */
// Our own choice: the Wishbone interface to the registers.
module fpec_top #(
   parameter int FLASH_KBYTES = 32
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic programming_supply_pin,
   input wire logic low_power_req,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [17:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [3:0] active_mode_o
);
   import fpec_pkg::*;

   // ----------------------------------------------------------------
   // variant decode
   // ----------------------------------------------------------------
   localparam logic [14:0] TOP_ADDR = (FLASH_KBYTES == 16) ? FPEC_TOP_16K :
      (FLASH_KBYTES == 24) ? FPEC_TOP_24K : FPEC_TOP_32K;
   // absent blocks: the select bit is kept but steers nothing
   localparam logic [3:0] LB_VALID = (FLASH_KBYTES == 16) ? 4'h3 :
      (FLASH_KBYTES == 24) ? 4'h7 : 4'hf;
   localparam logic [13:0] TOP_HALF = TOP_ADDR[14:1];

   // block map: one decoder shared by program and erase
   function automatic logic blk_sel(input logic [14:0] a,
                                    input logic [3:0] lb,
                                    input logic [7:0] sb);
      logic [3:0] lbv;
      lbv = lb & LB_VALID;
      if (a < FPEC_SB_128_END) begin
         blk_sel = sb[a[8:7]];
      end else if (a < FPEC_SB_512_END) begin
         blk_sel = sb[4];
      end else if (a < FPEC_SMALL_END) begin
         blk_sel = sb[3'(3'd4 + {1'b0, a[11:10]})];
      end else if (a < FPEC_LARGE0_END) begin
         blk_sel = lbv[0];
      end else begin
         blk_sel = lbv[a[14:13]];
      end
   endfunction

   // ----------------------------------------------------------------
   // supply pin synchroniser
   // ----------------------------------------------------------------
   logic supply_meta_reg;
   logic supply_sync_reg;

   // pin is asynchronous to clk_sys; second flop is the only reader
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         supply_meta_reg <= 1'b0;
         supply_sync_reg <= 1'b0;
      end else begin
         supply_meta_reg <= programming_supply_pin;
         supply_sync_reg <= supply_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // control state
   // ----------------------------------------------------------------
   fpec_state_e state_reg, state_next;
   logic [3:0] mode_reg, mode_next;
   logic [3:0] large_reg, large_next;
   logic [7:0] small_reg, small_next;
   logic [13:0] erase_cnt_reg, erase_cnt_next;
   logic erase_pend_reg, erase_pend_next;
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;

   fpec_mem_if mem_if ();

   logic req;
   logic [15:0] idx;
   logic [14:0] flash_addr;
   logic in_flash;
   logic reg_area;
   logic clear_regs;
   logic [15:0] merged;
   logic [7:0] mode_view;

   assign req = wb_cyc_i & wb_stb_i;
   assign idx = wb_adr_i[17:2];
   assign flash_addr = {idx[13:0], 1'b0};
   // array window runs from zero to the variant's top address
   assign in_flash = (idx[15:14] == 2'b00) && (flash_addr <= TOP_ADDR);
   assign reg_area = (idx >= FPEC_IDX_MODE) && (idx <= FPEC_IDX_SMALL);
   assign clear_regs = !supply_sync_reg | low_power_req;
   // live supply flag in the top bit
   assign mode_view = {supply_sync_reg, 3'b000, mode_reg} |
      (supply_sync_reg ? FPEC_MODE_SUPPLY_RESET : 8'h00);
   // program can only pull bits low; unselected lanes leave bits alone
   assign merged = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'hff,
                    wb_sel_i[0] ? wb_dat_i[7:0] : 8'hff};

   // next-state logic for bus answers, registers and erase sweep
   always_comb begin
      state_next = state_reg;
      mode_next = mode_reg;
      large_next = large_reg;
      small_next = small_reg;
      erase_cnt_next = erase_cnt_reg;
      erase_pend_next = erase_pend_reg;
      ack_next = 1'b0;
      dat_next = dat_reg;
      mem_if.addr = idx[13:0];
      mem_if.we = 1'b0;
      mem_if.wdata = mem_if.rdata & merged;
      unique case (state_reg)
         FPEC_ST_IDLE: begin
            if (req) begin
               state_next = FPEC_ST_ACCESS;
            end
         end
         FPEC_ST_ACCESS: begin
            // array data is ready here, answer on the next edge
            ack_next = 1'b1;
            state_next = FPEC_ST_DONE;
            dat_next = 32'h0000_0000;
            if (in_flash) begin
               dat_next = {16'h0000, mem_if.rdata};
            end else if (reg_area && !supply_sync_reg) begin
               // locked registers read as all ones
               dat_next = {24'h00_0000, FPEC_LOCKED_READ};
            end else if (idx == FPEC_IDX_MODE) begin
               dat_next = {24'h00_0000, mode_view};
            end else if (idx == FPEC_IDX_LARGE) begin
               dat_next = {24'h00_0000, FPEC_LARGE_FIXED, large_reg};
            end else if (idx == FPEC_IDX_SMALL) begin
               dat_next = {24'h00_0000, small_reg};
            end
            // writes only land while the supply is present
            if (wb_we_i && wb_sel_i[0] && supply_sync_reg) begin
               if (idx == FPEC_IDX_MODE) begin
                  // mode bits follow the written value
                  mode_next = wb_dat_i[3:0];
                  erase_pend_next = wb_dat_i[FPEC_BIT_ERASE] &&
                     !mode_reg[FPEC_BIT_ERASE];
               end else if (idx == FPEC_IDX_LARGE) begin
                  large_next = wb_dat_i[3:0];
               end else if (idx == FPEC_IDX_SMALL) begin
                  small_next = wb_dat_i[7:0];
               end
            end
            if (wb_we_i && in_flash && supply_sync_reg &&
                mode_reg[FPEC_BIT_PROG] &&
                blk_sel(flash_addr, large_reg, small_reg)) begin
               mem_if.we = 1'b1;
            end
         end
         FPEC_ST_DONE: begin
            erase_cnt_next = 14'h0000;
            erase_pend_next = 1'b0;
            state_next = erase_pend_reg ? FPEC_ST_ERASE : FPEC_ST_IDLE;
         end
         FPEC_ST_ERASE: begin
            // sweep the array, restoring ones in selected blocks
            mem_if.addr = erase_cnt_reg;
            mem_if.wdata = FPEC_ERASED;
            mem_if.we = blk_sel({erase_cnt_reg, 1'b0}, large_reg, small_reg);
            erase_cnt_next = erase_cnt_reg + 14'h0001;
            if (erase_cnt_reg == TOP_HALF) begin
               state_next = FPEC_ST_IDLE;
            end
         end
      endcase
      // clearing wins over any bus write to the registers; an array program write in the same cycle still lands when low_power_req causes the clear
      if (clear_regs) begin
         mode_next = FPEC_MODE_RESET;
         large_next = FPEC_LARGE_RESET[3:0];
         small_next = FPEC_SMALL_RESET;
         erase_pend_next = 1'b0;
         // losing the supply mid-sweep stops the erase at once
         if (state_reg == FPEC_ST_ERASE) begin
            state_next = FPEC_ST_IDLE;
            mem_if.we = 1'b0;
         end
      end
   end

   // register the next values
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_reg <= FPEC_ST_IDLE;
         mode_reg <= FPEC_MODE_RESET;
         large_reg <= FPEC_LARGE_RESET[3:0];
         small_reg <= FPEC_SMALL_RESET;
         erase_cnt_reg <= 14'h0000;
         erase_pend_reg <= 1'b0;
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         large_reg <= large_next;
         small_reg <= small_next;
         erase_cnt_reg <= erase_cnt_next;
         erase_pend_reg <= erase_pend_next;
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end

   fpec_mem u_mem (
      .clk_sys(clk_sys),
      .mem(mem_if.array)
   );

   // outputs straight from flops
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign active_mode_o = mode_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_read_two_states: assert property (
      state_reg == FPEC_ST_IDLE && req |-> ##2 wb_ack_o)
      else $error("access not answered two edges after request");

   a_map_top_bound: assert property (
      mem_if.we && state_reg == FPEC_ST_ACCESS |-> flash_addr <= TOP_ADDR)
      else $error("array write beyond the top address");

   a_locked_read_ones: assert property (
      state_reg == FPEC_ST_ACCESS && reg_area && !supply_sync_reg
      |=> wb_dat_o[7:0] == FPEC_LOCKED_READ)
      else $error("locked register read not all ones");

   a_mode_cleared: assert property (
      clear_regs |=> mode_reg == FPEC_MODE_RESET)
      else $error("mode control not cleared");

   a_supply_flag: assert property (
      state_reg == FPEC_ST_ACCESS && idx == FPEC_IDX_MODE && supply_sync_reg
      |=> wb_dat_o[FPEC_BIT_SUPPLY])
      else $error("supply flag missing from mode read");

   a_erase_verify_write: assert property (
      state_reg == FPEC_ST_ACCESS && wb_we_i && wb_sel_i[0] &&
      idx == FPEC_IDX_MODE && !clear_regs
      |=> active_mode_o[FPEC_BIT_ERASE_VERIFY] ==
          $past(wb_dat_i[FPEC_BIT_ERASE_VERIFY]))
      else $error("erase-verify bit did not follow write");

   a_large_reset_val: assert property (
      clear_regs |=> large_reg == FPEC_LARGE_RESET[3:0])
      else $error("large-block select not restored");

   a_large_upper_ones: assert property (
      state_reg == FPEC_ST_ACCESS && idx == FPEC_IDX_LARGE && supply_sync_reg
      |=> wb_dat_o[7:4] == FPEC_LARGE_FIXED)
      else $error("large-block upper nibble not ones");

   a_small_cleared: assert property (
      clear_regs |=> small_reg == FPEC_SMALL_RESET)
      else $error("small-block select not cleared");

   a_write_selected: assert property (
      mem_if.we |-> blk_sel({mem_if.addr, 1'b0}, large_reg, small_reg))
      else $error("array write into an unselected block");
endmodule
